// ---- verilog/gpp_pkg.sv ----
// Register map, field layout, reset values and address decode for the GPIO port block.
package gpp_pkg;

    // Number of ports and pins per port.
    localparam int unsigned GPP_NUM_PORTS = 3;
    localparam int unsigned GPP_P0_W = 5;
    localparam int unsigned GPP_P1_W = 2;
    localparam int unsigned GPP_P2_W = 7;
    localparam int unsigned GPP_IN_W = GPP_P0_W + GPP_P1_W + GPP_P2_W;

    // Register byte addresses.
    localparam logic [31:0] GPP_P0_DAT_ADDR = 32'hffff0d20;
    localparam logic [31:0] GPP_P0_SET_ADDR = 32'hffff0d24;
    localparam logic [31:0] GPP_P1_DAT_ADDR = 32'hffff0d30;
    localparam logic [31:0] GPP_P1_SET_ADDR = 32'hffff0d34;
    localparam logic [31:0] GPP_P2_DAT_ADDR = 32'hffff0d40;
    localparam logic [31:0] GPP_P2_SET_ADDR = 32'hffff0d44;

    // Field positions inside a data or set register; each field is one byte, bit i is line i.
    localparam int unsigned GPP_DIR_LSB = 24;
    localparam int unsigned GPP_OUT_LSB = 16;
    localparam int unsigned GPP_IN_LSB = 0;
    localparam int unsigned GPP_FLD_W = 8;

    // Byte lanes that carry the direction and output fields.
    localparam int unsigned GPP_DIR_LANE = 3;
    localparam int unsigned GPP_OUT_LANE = 2;

    // Values after reset: every line an input, every output latch low.
    localparam logic [7:0] GPP_DIR_RST = 8'h00;
    localparam logic [7:0] GPP_OUT_RST = 8'h00;

    // Implemented bits per port; port 2 line 4 has a direction bit and an input but no output latch.
    localparam logic [7:0] GPP_DIR_MASK [GPP_NUM_PORTS] = '{8'h1f, 8'h03, 8'h73};
    localparam logic [7:0] GPP_OUT_MASK [GPP_NUM_PORTS] = '{8'h1f, 8'h03, 8'h63};
    localparam logic [7:0] GPP_IN_MASK [GPP_NUM_PORTS] = '{8'h1f, 8'h03, 8'h73};

    // AXI response codes.
    localparam logic [1:0] GPP_RESP_OKAY = 2'h0;
    localparam logic [1:0] GPP_RESP_SLVERR = 2'h2;

    // Result of decoding a bus address.
    typedef struct packed {
        logic hit;
        logic is_set;
        logic [1:0] port;
    } gpp_dec_t;

    // Maps a byte address onto a port and register kind; the two low address bits are ignored.
    function automatic gpp_dec_t gpp_decode(input logic [31:0] addr);
        gpp_dec_t dec;
        dec = '0;
        unique case ({addr[31:2], 2'h0})
            GPP_P0_DAT_ADDR: dec = '{hit: 1'b1, is_set: 1'b0, port: 2'h0};
            GPP_P0_SET_ADDR: dec = '{hit: 1'b1, is_set: 1'b1, port: 2'h0};
            GPP_P1_DAT_ADDR: dec = '{hit: 1'b1, is_set: 1'b0, port: 2'h1};
            GPP_P1_SET_ADDR: dec = '{hit: 1'b1, is_set: 1'b1, port: 2'h1};
            GPP_P2_DAT_ADDR: dec = '{hit: 1'b1, is_set: 1'b0, port: 2'h2};
            GPP_P2_SET_ADDR: dec = '{hit: 1'b1, is_set: 1'b1, port: 2'h2};
            default: dec = '0;
        endcase
        return dec;
    endfunction

endpackage

// ---- verilog/gpp_reg_if.sv ----
// Register access strobes between the bus slave and the port register file.
`timescale 1ns/1ps
interface gpp_reg_if;
    logic wr_en;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;

    // The bus side issues accesses and collects data and errors.
    modport bus (
        output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        input wr_err, rd_data, rd_err
    );

    // The register side answers combinationally in the same cycle.
    modport regs (
        input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        output wr_err, rd_data, rd_err
    );
endinterface

// ---- verilog/gpp_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
module gpp_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // One pair of flip-flops per bit; the first stage feeds only the second.
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_reg;
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                meta_reg <= 1'b0;
                q[i] <= 1'b0;
            end else begin
                meta_reg <= d[i];
                q[i] <= meta_reg;
            end
        end
    end

endmodule

// ---- verilog/gpp_axil_slave.sv ----
// AXI4-Lite slave that turns bus transfers into single-cycle register strobes.
`timescale 1ns/1ps
module gpp_axil_slave
    import gpp_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Write address and data.
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response.
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address and data.
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side.
    gpp_reg_if.bus regs
);

    logic [31:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // A write fires once both halves are held and the previous answer is gone.
    assign regs.wr_en = !awready && !wready && !bvalid;
    assign regs.wr_addr = aw_addr_reg;
    assign regs.wr_data = w_data_reg;
    assign regs.wr_strb = w_strb_reg;

    // Reads are decoded straight from the address channel when it is taken.
    assign regs.rd_en = arvalid && arready;
    assign regs.rd_addr = araddr;

    // Write address and data are captured independently, in either order.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_addr_reg <= 32'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (bvalid && bready) begin
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Write response follows the strobe by one cycle and holds until taken.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= GPP_RESP_OKAY;
        end else if (regs.wr_en) begin
            bvalid <= 1'b1;
            bresp <= regs.wr_err ? GPP_RESP_SLVERR : GPP_RESP_OKAY;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read data is latched at the address handshake, so it stays fixed while rvalid waits.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= GPP_RESP_OKAY;
        end else if (regs.rd_en) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= regs.rd_data;
            rresp <= regs.rd_err ? GPP_RESP_SLVERR : GPP_RESP_OKAY;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // Each write strobe is answered on the next edge with a response.
    write_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
        regs.wr_en |=> bvalid && !$past(bvalid))
        else $error("write strobe not followed by a write response");

    // A read handshake raises rvalid and drops arready on the next edge.
    read_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
        (arvalid && arready) |=> rvalid && !arready)
        else $error("read handshake not followed by read data");

endmodule

// ---- verilog/gpp_top.sv ----
// GPIO ports 0 to 2: data registers, set registers, pin drive and input read-back.
//
// Contract
// - Port 2 line 5 is driven with the value held in its data-register output bit.
// - Port 2 lines 1 and 0 are driven with the values written to their output bits.
// - Read-only input bits report the present level of port 2 lines 6, 5 and 4; writes to them are ignored.
// - Port 2 lines 1 and 0 are reported in input bits 1 and 0 of the port 2 data register.
// - A write-only port 0 set register drives chosen port 0 pins high without touching the others.
// - A zero written to any set-register bit leaves that pin unchanged.
// - The port 1 set register raises chosen port 1 pins without disturbing the others.
// - A write-only port 2 set register raises chosen port 2 pins without a read-modify-write.
// - Bits 22 and 21 of the port 2 set register raise port 2 lines 6 and 5; a zero does nothing.
// - A port 2 line drives when its direction bit in the top byte is 1 and is an input when 0.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gpp_top
    import gpp_pkg::*;
(
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // AXI4-Lite write address and data.
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response.
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read channels.
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Port 0 pins.
    input wire logic [GPP_P0_W-1:0] P0_I,
    output logic [GPP_P0_W-1:0] P0_O,
    output logic [GPP_P0_W-1:0] P0_OE,
    // Port 1 pins.
    input wire logic [GPP_P1_W-1:0] P1_I,
    output logic [GPP_P1_W-1:0] P1_O,
    output logic [GPP_P1_W-1:0] P1_OE,
    // Port 2 pins.
    input wire logic [GPP_P2_W-1:0] P2_I,
    output logic [GPP_P2_W-1:0] P2_O,
    output logic [GPP_P2_W-1:0] P2_OE
);

    import gpp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave and input synchronisers.

    gpp_reg_if regs ();

    logic [GPP_IN_W-1:0] in_sync;
    logic [7:0] in_vec [GPP_NUM_PORTS];
    logic [7:0] dir_reg [GPP_NUM_PORTS];
    logic [7:0] dir_next [GPP_NUM_PORTS];
    logic [7:0] out_reg [GPP_NUM_PORTS];
    logic [7:0] out_next [GPP_NUM_PORTS];
    gpp_dec_t dec_w;
    gpp_dec_t dec_r;

    // Bus handshakes live in the slave; every AXI output there is a flip-flop.
    gpp_axil_slave u_slave (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .regs(regs.bus)
    );

    // Pins change at any time, so every input passes two flip-flops before it is read.
    gpp_sync #(
        .W(GPP_IN_W)
    ) u_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .d({P2_I, P1_I, P0_I}),
        .q(in_sync)
    );

    // Synchronised levels regrouped one byte per port, bit i being line i.
    assign in_vec[0] = {3'h0, in_sync[GPP_P0_W-1:0]};
    assign in_vec[1] = {6'h0, in_sync[GPP_P0_W+GPP_P1_W-1:GPP_P0_W]};
    assign in_vec[2] = {1'h0, in_sync[GPP_IN_W-1:GPP_P0_W+GPP_P1_W]};

    ////////////////////////////////////////////////////////////////////////////////
    // Register file.

    // Both paths share one decoder so reads and writes can never disagree on the map.
    assign dec_w = gpp_decode(regs.wr_addr);
    assign dec_r = gpp_decode(regs.rd_addr);
    assign regs.wr_err = !dec_w.hit;

    // Next direction and output values for every port.
    always_comb begin
        for (int p = 0; p < GPP_NUM_PORTS; p++) begin
            dir_next[p] = dir_reg[p];
            out_next[p] = out_reg[p];
            if (regs.wr_en && dec_w.hit && dec_w.port == 2'(p)) begin
                if (dec_w.is_set) begin
                    // ones only: zeros leave the latch alone.
                    if (regs.wr_strb[GPP_OUT_LANE]) begin
                        out_next[p] = out_reg[p] | (regs.wr_data[GPP_OUT_LSB +: GPP_FLD_W] & GPP_OUT_MASK[p]);
                    end
                end else begin
                    if (regs.wr_strb[GPP_DIR_LANE]) begin
                        dir_next[p] = regs.wr_data[GPP_DIR_LSB +: GPP_FLD_W] & GPP_DIR_MASK[p];
                    end
                    if (regs.wr_strb[GPP_OUT_LANE]) begin
                        out_next[p] = regs.wr_data[GPP_OUT_LSB +: GPP_FLD_W] & GPP_OUT_MASK[p];
                    end
                end
            end
        end
    end

    // Direction and output latches; reset leaves every line an input with a low latch.
    always_ff @(posedge CORE_CLK) begin
        for (int p = 0; p < GPP_NUM_PORTS; p++) begin
            if (!RST_N) begin
                dir_reg[p] <= GPP_DIR_RST;
                out_reg[p] <= GPP_OUT_RST;
            end else begin
                dir_reg[p] <= dir_next[p];
                out_reg[p] <= out_next[p];
            end
        end
    end

    // Read mux; input bits are read-only and set registers read back as zero.
    always_comb begin
        regs.rd_data = 32'h0;
        regs.rd_err = !dec_r.hit;
        if (dec_r.hit && !dec_r.is_set) begin
            // low inputs at bits 1 and 0.
            regs.rd_data[GPP_DIR_LSB +: GPP_FLD_W] = dir_reg[dec_r.port];
            regs.rd_data[GPP_OUT_LSB +: GPP_FLD_W] = out_reg[dec_r.port];
            regs.rd_data[GPP_IN_LSB +: GPP_FLD_W] = in_vec[dec_r.port] & GPP_IN_MASK[dec_r.port];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive.

    // latch drives the pin.
    // Pins come straight from the latches, so a pin follows a write one edge later.
    assign P0_O = out_reg[0][GPP_P0_W-1:0];
    assign P1_O = out_reg[1][GPP_P1_W-1:0];
    assign P2_O = out_reg[2][GPP_P2_W-1:0];

    assign P0_OE = dir_reg[0][GPP_P0_W-1:0];
    assign P1_OE = dir_reg[1][GPP_P1_W-1:0];
    assign P2_OE = dir_reg[2][GPP_P2_W-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    // Decoded write and read strobes that the checks look at.
    logic wr_p0_set;
    logic wr_p1_set;
    logic wr_p2_set;
    logic wr_p2_dat;
    logic rd_p2_dat;
    assign wr_p0_set = regs.wr_en && regs.wr_strb[GPP_OUT_LANE] && dec_w.hit && dec_w.is_set && dec_w.port == 2'h0;
    assign wr_p1_set = regs.wr_en && regs.wr_strb[GPP_OUT_LANE] && dec_w.hit && dec_w.is_set && dec_w.port == 2'h1;
    assign wr_p2_set = regs.wr_en && regs.wr_strb[GPP_OUT_LANE] && dec_w.hit && dec_w.is_set && dec_w.port == 2'h2;
    assign wr_p2_dat = regs.wr_en && dec_w.hit && !dec_w.is_set && dec_w.port == 2'h2;
    assign rd_p2_dat = regs.rd_en && dec_r.hit && !dec_r.is_set && dec_r.port == 2'h2;

    // Remembers a line 5 set until a data write replaces the output byte,
    // so the read-back check also covers reads that come many cycles later.
    logic line5_set_reg;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            line5_set_reg <= 1'b0;
        end else if (wr_p2_dat && regs.wr_strb[GPP_OUT_LANE]) begin
            line5_set_reg <= 1'b0;
        end else if (wr_p2_set && regs.wr_data[21]) begin
            line5_set_reg <= 1'b1;
        end
    end

    // Steps of a set followed by a read-back.
    sequence set_line5_s;
        wr_p2_set && regs.wr_data[21];
    endsequence
    sequence read_p2_s;
        rd_p2_dat;
    endsequence

    line5_drive_a: assert property (
        (wr_p2_dat && regs.wr_strb[GPP_OUT_LANE]) |=> P2_O[5] == $past(regs.wr_data[21]))
        else $error("port 2 line 5 does not follow its output bit");

    low_lines_drive_a: assert property (
        (wr_p2_dat && regs.wr_strb[GPP_OUT_LANE]) |=> P2_O[1:0] == $past(regs.wr_data[17:16]))
        else $error("port 2 lines 1 and 0 do not follow their output bits");

    high_inputs_a: assert property (
        rd_p2_dat |-> regs.rd_data[6:4] == $past(P2_I[6:4], 2))
        else $error("port 2 lines 6 to 4 read back wrong");

    low_inputs_a: assert property (
        rd_p2_dat |-> regs.rd_data[1:0] == $past(P2_I[1:0], 2) && regs.rd_data[3:2] == 2'h0)
        else $error("port 2 lines 1 and 0 read back wrong");

    port0_set_a: assert property (
        wr_p0_set |=> P0_O == ($past(P0_O) | $past(regs.wr_data[20:16])))
        else $error("port 0 set register did not raise the chosen lines");

    zero_keeps_a: assert property (
        (wr_p0_set && !regs.wr_data[16]) |=> P0_O[0] == $past(P0_O[0]))
        else $error("a zero in the set register changed a pin");

    port1_set_a: assert property (
        wr_p1_set |=> P1_O == ($past(P1_O) | $past(regs.wr_data[17:16])))
        else $error("port 1 set register did not raise the chosen lines");

    port2_set_a: assert property (
        wr_p2_set |=> P2_O[6:5] == ($past(P2_O[6:5]) | $past(regs.wr_data[22:21]))
            && P2_O[1:0] == ($past(P2_O[1:0]) | $past(regs.wr_data[17:16])) && !P2_O[4])
        else $error("port 2 set register did not raise the chosen lines");

    port2_dir_a: assert property (
        (wr_p2_dat && regs.wr_strb[GPP_DIR_LANE]) |=>
            P2_OE == {$past(regs.wr_data[30:28]), 2'h0, $past(regs.wr_data[25:24])})
        else $error("port 2 output enables do not follow the direction bits");

    // A line 5 set shows on the pin and arms the read-back flag.
    line5_set_a: assert property (
        set_line5_s |=> P2_O[5] && line5_set_reg)
        else $error("port 2 line 5 did not rise after its set bit");

    // A set is no read-modify-write: it may touch the output latch only.
    set_rmw_a: assert property (
        wr_p2_set |=> $stable(P2_OE))
        else $error("port 2 set write changed a direction bit");

    // Port 1 directions survive a set.
    port1_keep_a: assert property (
        wr_p1_set |=> $stable(P1_OE))
        else $error("port 1 set write changed a direction bit");

    // Port 0 directions survive a set.
    port0_keep_a: assert property (
        wr_p0_set |=> $stable(P0_OE))
        else $error("port 0 set write changed a direction bit");

    // A zero in bit 22 keeps line 6 as it was.
    zero_keeps2_a: assert property (
        (wr_p2_set && !regs.wr_data[22]) |=> P2_O[6] == $past(P2_O[6]))
        else $error("a zero in the port 2 set register changed a pin");

    // Nothing but the input field may show in the low half of a port 2 read.
    p2_low_half_a: assert property (
        rd_p2_dat |-> regs.rd_data[15:7] == 9'h000)
        else $error("port 2 read shows bits above the input field");

    // The flag stands for a set that no data write has overwritten since.
    set_readback_a: assert property (
        read_p2_s |-> !line5_set_reg || regs.rd_data[21])
        else $error("set write did not read back in the data register");

endmodule

// ---- test/gpio_port_set_and_data_tb_top.sv ----
// Self-checking bench for the GPIO port data and set registers over AXI4-Lite.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module gpio_port_set_and_data_tb_top;
    import gpp_pkg::*;

    // Read notes pair the expected word with its response code.
    typedef struct {logic [31:0] d; logic [1:0] r;} gpp_rd_note_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] awaddr = '0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [31:0] araddr = '0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [GPP_P0_W-1:0] p0_o, p0_oe;
    logic [GPP_P1_W-1:0] p1_o, p1_oe;
    logic [GPP_P2_W-1:0] p2_o, p2_oe;
    logic [7:0] in_m [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] dir_m [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] out_m [3] = '{8'h00, 8'h00, 8'h00};
    logic [31:0] dat_a [3] = '{GPP_P0_DAT_ADDR, GPP_P1_DAT_ADDR, GPP_P2_DAT_ADDR};
    logic [31:0] set_a [3] = '{GPP_P0_SET_ADDR, GPP_P1_SET_ADDR, GPP_P2_SET_ADDR};
    logic [31:0] rnd;
    logic [7:0] s;
    int seed = 32'h1324e6b9;
    int errors = 0;
    int comparisons = 0;
    gpp_rd_note_t rq [$];
    gpp_rd_note_t rn;
    logic [1:0] bq [$];
    logic [1:0] bx;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz.
    always #5 clk = ~clk;

    gpp_top uut (.CORE_CLK(clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .P0_I(in_m[0][GPP_P0_W-1:0]), .P0_O(p0_o), .P0_OE(p0_oe),
        .P1_I(in_m[1][GPP_P1_W-1:0]), .P1_O(p1_o), .P1_OE(p1_oe),
        .P2_I(in_m[2][GPP_P2_W-1:0]), .P2_O(p2_o), .P2_OE(p2_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor takes the oldest note at each response handshake; edge values are pre-update.
    always @(posedge clk) begin
        if (bvalid && bready) begin
            bx = bq.pop_front();
            `CHK("bresp", bx, bresp);
        end
        if (rvalid && rready) begin
            rn = rq.pop_front();
            `CHK("rdata", rn.d, rdata);
            `CHK("rresp", rn.r, rresp);
        end
    end

    // Expected data word: direction, output latch, zero byte, input levels.
    function automatic logic [31:0] exp_dat(input int p);
        return {dir_m[p], out_m[p], 8'h00, in_m[p]};
    endfunction

    // One write; ready is looked at before the edge that samples it, so no race.
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] r);
        int n = 0;
        bit haw = 0;
        bit hw = 0;
        bit hb = 0;
        bq.push_back(r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb && n < 100) begin
            @(negedge clk);
            n++;
            haw = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            @(posedge clk);
            if (haw) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
        end
        if (!hb) begin errors++; $display("Error bvalid expected 1 seen 0"); end
    endtask

    // One read with the same sampling scheme.
    task automatic axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        bit har = 0;
        bit hr = 0;
        rq.push_back('{d, r});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hr && n < 100) begin
            @(negedge clk);
            n++;
            har = arvalid && arready;
            hr = rvalid && rready;
            @(posedge clk);
            if (har) arvalid <= 1'b0;
            if (hr) rready <= 1'b0;
        end
        if (!hr) begin errors++; $display("Error rvalid expected 1 seen 0"); end
    endtask

    // Pins must follow the latch and direction model.
    task automatic chk_pins();
        @(negedge clk);
        `CHK("p0_o", out_m[0][GPP_P0_W-1:0], p0_o);
        `CHK("p0_oe", dir_m[0][GPP_P0_W-1:0], p0_oe);
        `CHK("p1_o", out_m[1][GPP_P1_W-1:0], p1_o);
        `CHK("p1_oe", dir_m[1][GPP_P1_W-1:0], p1_oe);
        `CHK("p2_o", out_m[2][GPP_P2_W-1:0], p2_o);
        `CHK("p2_oe", dir_m[2][GPP_P2_W-1:0], p2_oe);
    endtask

    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog sized well above the few hundred cycles the tests need.
    initial begin
        #200000;
        errors++;
        $display("Error watchdog expected done seen hang");
        stop_test();
    end

    // Main sequence.
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // Reset state: pins idle, data words hold only inputs, set registers read zero.
        chk_pins();
        for (int p = 0; p < 3; p++) begin
            axi_rd(dat_a[p], exp_dat(p), GPP_RESP_OKAY);
            axi_rd(set_a[p], 32'h0, GPP_RESP_OKAY);
        end
        $display("test reset done");
        // Random data writes, then sets OR-ed into the latch, a zero set, and read-back.
        for (int k = 0; k < 4; k++) begin
            for (int p = 0; p < 3; p++) begin
                rnd = $random(seed);
                @(posedge clk);
                in_m[p] <= rnd[7:0] & GPP_IN_MASK[p];
                dir_m[p] = rnd[31:24] & GPP_DIR_MASK[p];
                out_m[p] = rnd[23:16] & GPP_OUT_MASK[p];
                axi_wr(dat_a[p], {dir_m[p], out_m[p], 16'h0}, 4'hc, GPP_RESP_OKAY);
                chk_pins();
                s = rnd[15:8] & GPP_OUT_MASK[p];
                out_m[p] = out_m[p] | s;
                // set raises chosen lines, reserved zero
                axi_wr(set_a[p], {8'h00, s, 16'h0}, 4'hf, GPP_RESP_OKAY);
                chk_pins();
                axi_wr(set_a[p], 32'h0, 4'hf, GPP_RESP_OKAY);
                chk_pins();
                axi_rd(dat_a[p], exp_dat(p), GPP_RESP_OKAY);
            end
        end
        $display("test data and set done");
        // Lane strobes: direction byte alone, then output byte alone.
        dir_m[2] = GPP_DIR_MASK[2];
        axi_wr(dat_a[2], {GPP_DIR_MASK[2], 24'h0}, 4'h8, GPP_RESP_OKAY);
        chk_pins();
        out_m[2] = 8'h00;
        axi_wr(dat_a[2], 32'h0, 4'h4, GPP_RESP_OKAY);
        chk_pins();
        axi_wr(set_a[2], 32'h00600000, 4'hf, GPP_RESP_OKAY);
        out_m[2] = 8'h60;
        chk_pins();
        axi_rd(dat_a[2], exp_dat(2), GPP_RESP_OKAY);
        $display("test strobes done");
        // Unmapped word after the port 2 set register: refused, nothing moves.
        axi_wr(GPP_P2_SET_ADDR + 32'h4, 32'h00600000, 4'hf, GPP_RESP_SLVERR);
        chk_pins();
        axi_rd(GPP_P2_SET_ADDR + 32'h4, 32'h0, GPP_RESP_SLVERR);
        axi_rd(dat_a[2], exp_dat(2), GPP_RESP_OKAY);
        $display("test unmapped done");
        repeat (3) @(posedge clk);
        stop_test();
    end
endmodule
